// *** include/sdf_pkg.sv ***
// Function
// - Header is one all-ones then two zeros
// - Tolerant mode: 3FC-3FF ones, 000-003 zero
// - Strict mode: only exact 3FF and 000
// - Invalid header: EAV line, SAV hblank error
// - Flag loss of signal when input absent
// - Flag missing or misplaced timing references
// - Count active samples, flag misplaced EAV
// - Count blanking samples, flag misplaced SAV
// - Wrong V in both markers: vblank, status
// - Count field lines, flag invalid count
// - Clear zeros counters, keeping an error pulse of that cycle as 1; restarts halted monitor
// - Errored seconds count seconds with errors
// - Elapsed seconds since last clear
`default_nettype none
package sdf_pkg;

   // ==========================================
   // Clock and timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int SEC_NS        = 1000000000;
   localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
   localparam int LOS_TIME_NS   = 1000;
   localparam int LOS_CYCLES    = (LOS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SEC_W         = 26;
   localparam int LOS_W         = 8;

   // ==========================================
   // Word values
   localparam int            WORD_W      = 10;
   localparam logic [9:0]    WORD_ONES   = 10'h3FF;
   localparam logic [9:0]    WORD_ZERO   = 10'h000;
   localparam logic [7:0]    NEAR_ONES   = 8'hFF;
   localparam logic [7:0]    NEAR_ZERO   = 8'h00;
   localparam int            XYZ_ONE_BIT = 9;
   localparam int            XYZ_F_BIT   = 8;
   localparam int            XYZ_V_BIT   = 7;
   localparam int            XYZ_H_BIT   = 6;

   // ==========================================
   // Line and field geometry, 525-line component
   localparam int         SAMP_W        = 12;
   localparam int         LINE_W        = 10;
   localparam logic [11:0] ACTIVE_SPAN  = 12'h5A4;  // 1440 active + 4 marker words
   localparam logic [11:0] HBLANK_SPAN  = 12'h110;  // 268 blanking + 4 marker words
   localparam logic [11:0] LINE_MAX     = 12'h6C0;  // Beyond one whole line plus slack
   localparam logic [9:0]  FIELD_LINES_A = 10'h106; // 262
   localparam logic [9:0]  FIELD_LINES_B = 10'h107; // 263
   localparam logic [9:0]  VBLANK_LINES  = 10'h014; // 20

   // ==========================================
   // Counters
   localparam int CNT_W    = 16;
   localparam int N_ERR    = 7;
   localparam int N_CNT    = N_ERR + 2;
   localparam int CNT_ESEC = N_ERR;
   localparam int CNT_ELAP = N_ERR + 1;

   typedef struct packed {
      logic field_len;
      logic status_word_error;
      logic vblank_len;
      logic hblank_len;
      logic line_len;
      logic trs_align;
      logic los;
   } sdf_err_t;

   typedef enum logic [1:0] {
      SDF_HUNT  = 2'b00,
      SDF_ONES  = 2'b01,
      SDF_ZERO1 = 2'b11,
      SDF_ZERO2 = 2'b10
   } sdf_hdr_t;

endpackage
`default_nettype wire

// *** rtl/sdf_sat_cnt.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdf_sat_cnt #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         sys_rst_in,
   // Control
   input  wire logic         clr_in,
   input  wire logic         inc_in,
   // Count
   output logic [W-1:0]      count_out
);

   logic [W-1:0] count_next;
   logic         at_max;

   always_comb begin
      at_max = &count_out;
      count_next = count_out;
      if (clr_in) begin
         // Event in the clearing cycle is kept
         count_next = inc_in ? W'(1) : '0;
      end else if (inc_in && !at_max) begin
         count_next = count_out + W'(1);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         count_out <= '0;
      end else begin
         count_out <= count_next;
      end
   end

endmodule
`default_nettype wire

// *** rtl/sdf_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdf_checker #(
   parameter int ONE_SEC_CYCLES = sdf_pkg::SEC_CYCLES
) (
   // Clock and reset
   input  wire logic                                       sys_clk_in,
   input  wire logic                                       sys_rst_in,
   // Link from the video source
   input  wire logic                                       link_clk_in,
   input  wire logic [sdf_pkg::WORD_W-1:0]                 link_word_in,
   // Control
   input  wire logic                                       strict_in,
   input  wire logic                                       clear_in,
   input  wire sdf_pkg::sdf_err_t                          trigger_mask_in,
   // Status
   output sdf_pkg::sdf_err_t                               err_pulse_out,
   output logic                                            los_out,
   output logic                                            halted_out,
   output logic                                            strict_active_out,
   // Counters
   output logic [sdf_pkg::N_CNT-1:0][sdf_pkg::CNT_W-1:0]   count_out
);

   // ==========================================
   // Link input synchronisers
   logic                        lclk_s1_reg;
   logic                        lclk_s2_reg;
   logic                        lclk_s3_reg;
   logic [sdf_pkg::WORD_W-1:0]  word_s1_reg;
   logic [sdf_pkg::WORD_W-1:0]  word_s2_reg;
   logic                        word_stb;

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         lclk_s1_reg <= 1'b0;
         lclk_s2_reg <= 1'b0;
         lclk_s3_reg <= 1'b0;
         word_s1_reg <= '0;
         word_s2_reg <= '0;
      end else begin
         lclk_s1_reg <= link_clk_in;
         lclk_s2_reg <= lclk_s1_reg;
         lclk_s3_reg <= lclk_s2_reg;
         word_s1_reg <= link_word_in;
         word_s2_reg <= word_s1_reg;
      end
   end

   // Word taken on rising link edge; source must hold it over that edge
   assign word_stb = lclk_s2_reg & ~lclk_s3_reg;

   // ==========================================
   // Loss of signal
   logic [sdf_pkg::LOS_W-1:0] idle_reg;
   logic [sdf_pkg::LOS_W-1:0] idle_next;
   logic                      los_next;

   always_comb begin
      idle_next = idle_reg;
      if (word_stb) begin
         idle_next = '0;
      end else if (idle_reg < sdf_pkg::LOS_W'(sdf_pkg::LOS_CYCLES)) begin
         idle_next = idle_reg + sdf_pkg::LOS_W'(1);
      end
      los_next = (idle_next >= sdf_pkg::LOS_W'(sdf_pkg::LOS_CYCLES));
   end

   // ==========================================
   // Header recognition
   sdf_pkg::sdf_hdr_t          hdr_reg;
   sdf_pkg::sdf_hdr_t          hdr_next;
   logic                       exact_reg;
   logic                       exact_next;
   logic                       strict_reg;
   logic                       strict_next;
   logic                       near_ones;
   logic                       near_zero;
   logic                       is_ones;
   logic                       is_zero;
   logic                       xyz_stb;
   logic                       hdr_bad;

   always_comb begin
      near_ones = (word_s2_reg[9:2] == sdf_pkg::NEAR_ONES);
      near_zero = (word_s2_reg[9:2] == sdf_pkg::NEAR_ZERO);
      is_ones   = (word_s2_reg == sdf_pkg::WORD_ONES);
      is_zero   = (word_s2_reg == sdf_pkg::WORD_ZERO);
      hdr_next  = hdr_reg;
      exact_next = exact_reg;
      xyz_stb   = 1'b0;
      if (word_stb) begin
         unique case (hdr_reg)
            sdf_pkg::SDF_HUNT: begin
               if (near_ones) begin
                  hdr_next = sdf_pkg::SDF_ONES;
                  exact_next = is_ones;
               end
            end
            sdf_pkg::SDF_ONES: begin
               if (near_zero) begin
                  hdr_next = sdf_pkg::SDF_ZERO1;
                  exact_next = exact_reg & is_zero;
               end else if (!near_ones) begin
                  hdr_next = sdf_pkg::SDF_HUNT;
               end else begin
                  exact_next = is_ones;
               end
            end
            sdf_pkg::SDF_ZERO1: begin
               if (near_zero) begin
                  hdr_next = sdf_pkg::SDF_ZERO2;
                  exact_next = exact_reg & is_zero;
               end else begin
                  hdr_next = sdf_pkg::SDF_HUNT;
               end
            end
            sdf_pkg::SDF_ZERO2: begin
               hdr_next = sdf_pkg::SDF_HUNT;
               xyz_stb = 1'b1;
            end
         endcase
      end
      // Strict rejects a header that only tolerant matching accepts
      hdr_bad = xyz_stb & strict_reg & ~exact_reg;
      strict_next = strict_reg;
      if (xyz_stb && word_s2_reg[sdf_pkg::XYZ_H_BIT]) begin
         // Mode changes only at EAV, so a line never mixes settings
         strict_next = strict_in;
      end
   end

   // ==========================================
   // Line, blanking and field checks
   logic [sdf_pkg::SAMP_W-1:0] samp_reg;
   logic [sdf_pkg::SAMP_W-1:0] samp_next;
   logic [sdf_pkg::LINE_W-1:0] line_reg;
   logic [sdf_pkg::LINE_W-1:0] line_next;
   logic                       last_eav_reg;
   logic                       last_eav_next;
   logic                       synced_reg;
   logic                       synced_next;
   logic                       fld_reg;
   logic                       fld_next;
   logic                       eav_vbad_reg;
   logic                       eav_vbad_next;
   logic                       is_eav;
   logic                       v_exp;
   logic                       v_bad;
   sdf_pkg::sdf_err_t          ev;

   always_comb begin
      samp_next     = samp_reg;
      line_next     = line_reg;
      last_eav_next = last_eav_reg;
      synced_next   = synced_reg;
      fld_next      = fld_reg;
      eav_vbad_next = eav_vbad_reg;
      ev            = '0;
      is_eav = word_s2_reg[sdf_pkg::XYZ_H_BIT];
      v_exp  = (line_reg < sdf_pkg::VBLANK_LINES);
      v_bad  = (word_s2_reg[sdf_pkg::XYZ_V_BIT] != v_exp);
      ev.los = los_next & ~los_out;
      if (word_stb) begin
         samp_next = samp_reg + sdf_pkg::SAMP_W'(1);
         if (samp_reg >= sdf_pkg::LINE_MAX) begin
            // No marker for a whole line: report once, then re-hunt
            ev.trs_align = synced_reg;
            synced_next = 1'b0;
            samp_next = '0;
         end
      end
      if (hdr_bad) begin
         ev.line_len   = is_eav;
         ev.hblank_len = ~is_eav;
      end else if (xyz_stb) begin
         samp_next = '0;
         synced_next = 1'b1;
         last_eav_next = is_eav;
         ev.status_word_error = ~word_s2_reg[sdf_pkg::XYZ_ONE_BIT];
         if (synced_reg && (last_eav_reg == is_eav)) begin
            ev.trs_align = 1'b1;
         end else if (synced_reg && is_eav) begin
            ev.line_len = (samp_reg + sdf_pkg::SAMP_W'(1) != sdf_pkg::ACTIVE_SPAN);
         end else if (synced_reg) begin
            ev.hblank_len = (samp_reg + sdf_pkg::SAMP_W'(1) != sdf_pkg::HBLANK_SPAN);
         end
         if (is_eav) begin
            eav_vbad_next = v_bad;
            line_next = line_reg + sdf_pkg::LINE_W'(1);
            if (word_s2_reg[sdf_pkg::XYZ_F_BIT] != fld_reg) begin
               fld_next = word_s2_reg[sdf_pkg::XYZ_F_BIT];
               line_next = sdf_pkg::LINE_W'(1);
               ev.field_len = synced_reg
                  && (line_reg != sdf_pkg::FIELD_LINES_A)
                  && (line_reg != sdf_pkg::FIELD_LINES_B);
            end
         end else if (eav_vbad_reg && v_bad) begin
            ev.vblank_len = 1'b1;
            ev.status_word_error = 1'b1;
         end
      end
   end

   // ==========================================
   // Halt, seconds and error gating
   logic                       halted_next;
   sdf_pkg::sdf_err_t          err_next;
   logic [sdf_pkg::SEC_W-1:0]  sec_reg;
   logic [sdf_pkg::SEC_W-1:0]  sec_next;
   logic                       sec_err_reg;
   logic                       sec_err_next;
   logic                       sec_tick;
   logic [sdf_pkg::N_CNT-1:0]  inc;

   always_comb begin
      err_next = halted_out ? '0 : ev;
      // A trigger in the clearing cycle halts a running monitor; a halted one is released
      halted_next = (halted_out & ~clear_in) | (|(err_next & trigger_mask_in));
      sec_tick = (sec_reg == sdf_pkg::SEC_W'(ONE_SEC_CYCLES - 1));
      sec_next = sec_tick ? '0 : sec_reg + sdf_pkg::SEC_W'(1);
      sec_err_next = sec_err_reg;
      if (clear_in) begin
         sec_next = '0;
      end
      if (sec_tick || clear_in) begin
         sec_err_next = 1'b0;
      end
      if (|err_next) begin
         sec_err_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         // Start idle-saturated so loss of signal holds until a link edge
         idle_reg          <= sdf_pkg::LOS_W'(sdf_pkg::LOS_CYCLES);
         los_out           <= 1'b1;
         hdr_reg           <= sdf_pkg::SDF_HUNT;
         exact_reg         <= 1'b0;
         strict_reg        <= 1'b0;
         samp_reg          <= '0;
         line_reg          <= '0;
         last_eav_reg      <= 1'b0;
         synced_reg        <= 1'b0;
         fld_reg           <= 1'b0;
         eav_vbad_reg      <= 1'b0;
         halted_out        <= 1'b0;
         err_pulse_out     <= '0;
         sec_reg           <= '0;
         sec_err_reg       <= 1'b0;
         strict_active_out <= 1'b0;
      end else begin
         idle_reg          <= idle_next;
         los_out           <= los_next;
         hdr_reg           <= hdr_next;
         exact_reg         <= exact_next;
         strict_reg        <= strict_next;
         samp_reg          <= samp_next;
         line_reg          <= line_next;
         last_eav_reg      <= last_eav_next;
         synced_reg        <= synced_next;
         fld_reg           <= fld_next;
         eav_vbad_reg      <= eav_vbad_next;
         halted_out        <= halted_next;
         err_pulse_out     <= err_next;
         sec_reg           <= sec_next;
         sec_err_reg       <= sec_err_next;
         strict_active_out <= strict_next;
      end
   end

   // ==========================================
   // Counters
   always_comb begin
      inc = '0;
      inc[sdf_pkg::N_ERR-1:0] = err_pulse_out;
      inc[sdf_pkg::CNT_ESEC]  = sec_tick & (sec_err_reg | (|err_next)) & ~clear_in;
      inc[sdf_pkg::CNT_ELAP]  = sec_tick & ~clear_in;
   end

   for (genvar i = 0; i < sdf_pkg::N_CNT; i++) begin : g_cnt
      sdf_sat_cnt #(
         .W          (sdf_pkg::CNT_W)
      ) u_cnt (
         .sys_clk_in (sys_clk_in),
         .sys_rst_in (sys_rst_in),
         .clr_in     (clear_in),
         .inc_in     (inc[i]),
         .count_out  (count_out[i])
      );
   end

endmodule
`default_nettype wire

// *** bench/sdf_video_src.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Video source on the far side of the link
module sdf_video_src (
   // Link
   output logic       link_clk_out,
   output logic [9:0] link_word_out
);
   initial begin
      link_clk_out  = 1'b0;
      link_word_out = 10'h155;
   end
   // Clock stands low between words; odd offset keeps rising edges off the system clock edges
   task automatic send(input logic [9:0] w);
      #3 link_word_out = w;
      #80 link_clk_out = 1'b1;
      #77 link_clk_out = 1'b0;
   endtask
   // Released line shows the inverse of the last word
   task automatic idle();
      link_word_out = ~link_word_out;
   endtask
endmodule
`default_nettype wire

// *** bench/sdf_checker_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker
module sdf_checker_monitor #(
   parameter int ONE_SEC_CYCLES = sdf_pkg::SEC_CYCLES
) (
   // Clock and reset
   input wire logic                                          sys_clk_in,
   input wire logic                                          sys_rst_in,
   // Watched ports
   input wire logic                                          link_clk_in,
   input wire logic                                          clear_in,
   input wire sdf_pkg::sdf_err_t                             trigger_mask_in,
   input wire sdf_pkg::sdf_err_t                             err_pulse_out,
   input wire logic                                          los_out,
   input wire logic                                          halted_out,
   input wire logic [sdf_pkg::N_CNT-1:0][sdf_pkg::CNT_W-1:0] count_out
);
   logic        link_q_reg;
   logic [15:0] idle_reg;
   logic [31:0] sec_reg;
   logic        small_cnt;
   always_comb begin
      small_cnt = 1'b1;
      for (int i = 0; i < sdf_pkg::N_CNT; i++) begin
         if (count_out[i] > 16'h0001) small_cnt = 1'b0;
      end
   end
   // Raw link clock idle time; saturates so a long stall never wraps
   always_ff @(posedge sys_clk_in) begin
      link_q_reg <= link_clk_in;
      if (sys_rst_in || link_q_reg != link_clk_in) idle_reg <= 16'h0000;
      else if (idle_reg != 16'hFFFF) idle_reg <= idle_reg + 16'h0001;
      if (sys_rst_in || clear_in || $changed(count_out[8])) sec_reg <= 32'h0;
      else sec_reg <= sec_reg + 32'h1;
   end
   rst_values_a: assert property (@(posedge sys_clk_in)
      sys_rst_in |=> count_out == '0 && los_out && !halted_out && err_pulse_out == '0)
      else $error("reset values wrong");
   clear_zero_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      clear_in |=> small_cnt) else $error("clear left a count");
   pulse_once_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      err_pulse_out.line_len |=> !err_pulse_out.line_len) else $error("pulse too long");
   line_inc_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      err_pulse_out.line_len && !clear_in && count_out[2] != 16'hFFFF
      |=> count_out[2] == $past(count_out[2]) + 16'h0001) else $error("no increment");
   hblank_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      !err_pulse_out.hblank_len && !clear_in |=> $stable(count_out[3]))
      else $error("count moved without error");
   halt_quiet_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      halted_out && $past(halted_out) |-> err_pulse_out == '0) else $error("error while halted");
   halt_set_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (err_pulse_out & trigger_mask_in) != '0 |-> ##[0:1] halted_out) else $error("no halt");
   los_level_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      err_pulse_out.los |-> ##[0:1] los_out) else $error("los pulse without level");
   los_time_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      idle_reg > 16'd62 |-> los_out) else $error("los missed");
   los_drop_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      $rose(link_clk_in) && los_out |-> ##[1:10] !los_out) else $error("los stuck");
   esec_bound_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      count_out[7] <= count_out[8]) else $error("errored above elapsed");
   sec_step_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      sec_reg <= ONE_SEC_CYCLES + 2) else $error("elapsed late");
endmodule
bind sdf_checker sdf_checker_monitor #(
   .ONE_SEC_CYCLES(ONE_SEC_CYCLES)
) u_monitor (
   .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .link_clk_in(link_clk_in),
   .clear_in(clear_in), .trigger_mask_in(trigger_mask_in), .err_pulse_out(err_pulse_out),
   .los_out(los_out), .halted_out(halted_out), .count_out(count_out)
);
`default_nettype wire

// *** bench/sdf_checker_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench
module sdf_checker_test;
   localparam int         SEC = 2000;
   // EAV and SAV with V set, as lines near field start expect; VEAV and VSAV with V clear
   localparam logic [9:0] EAV  = 10'h2C0;
   localparam logic [9:0] SAV  = 10'h280;
   localparam logic [9:0] VEAV = 10'h240;
   localparam logic [9:0] VSAV = 10'h200;
   logic                                            sys_clk_in;
   logic                                            sys_rst_in = 1'b1;
   logic                                            strict_in = 1'b0;
   logic                                            clear_in = 1'b0;
   sdf_pkg::sdf_err_t                               mask = '0;
   sdf_pkg::sdf_err_t                               pulse;
   logic                                            los;
   logic                                            halted;
   logic                                            strict_act;
   logic [sdf_pkg::N_CNT-1:0][sdf_pkg::CNT_W-1:0]   cnt;
   wire logic                                       link_clk;
   wire logic [9:0]                                 link_word;
   int                                              fail_count = 0;
   int                                              cmp_count = 0;
   int                                              cyc = 0;
   int                                              clr_cyc = 0;
   sdf_video_src src (.link_clk_out(link_clk), .link_word_out(link_word));
   // Short second keeps the seconds counters moving within the run
   sdf_checker #(.ONE_SEC_CYCLES(SEC)) DUT (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .link_clk_in(link_clk),
      .link_word_in(link_word), .strict_in(strict_in), .clear_in(clear_in),
      .trigger_mask_in(mask), .err_pulse_out(pulse), .los_out(los), .halted_out(halted),
      .strict_active_out(strict_act), .count_out(cnt)
   );
   initial begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end
   always @(posedge sys_clk_in) cyc <= cyc + 1;
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic seg(input logic [9:0] xyz, input logic [9:0] o, input logic [9:0] z1,
                      input logic [9:0] z2, input int n);
      src.send(o);
      src.send(z1);
      src.send(z2);
      src.send(xyz);
      repeat (n) src.send(10'h040);
   endtask
   task automatic clr();
      @(negedge sys_clk_in) clear_in = 1'b1;
      @(negedge sys_clk_in) clear_in = 1'b0;
      clr_cyc = cyc;
      for (int i = 0; i < sdf_pkg::N_CNT; i++) check("count zero", cnt[i], 16'h0000);
   endtask
   task automatic stop_test();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge sys_clk_in);
      fail_count++;
      stop_test();
   end
   initial begin
      int l0;
      int h0;
      int e;
      repeat (6) @(negedge sys_clk_in);
      sys_rst_in = 1'b0;
      repeat (2) @(negedge sys_clk_in);
      check("los reset", los, 16'h1);
      check("halt reset", halted, 16'h0);
      seg(EAV, 10'h3FF, 10'h000, 10'h000, 268);
      seg(SAV, 10'h3FF, 10'h000, 10'h000, 1440);
      clr();
      check("los live", los, 16'h0);
      // Near headers pass while tolerant; strict request lands only at the next EAV
      seg(EAV, 10'h3FC, 10'h003, 10'h001, 268);
      @(negedge sys_clk_in) strict_in = 1'b1;
      check("mode held", strict_act, 16'h0);
      seg(SAV, 10'h3FD, 10'h002, 10'h000, 1440);
      check("line tol", cnt[2], 16'h0);
      check("hblank tol", cnt[3], 16'h0);
      check("align ok", cnt[1], 16'h0);
      seg(EAV, 10'h3FF, 10'h000, 10'h000, 268);
      check("mode strict", strict_act, 16'h1);
      seg(SAV, 10'h3FF, 10'h000, 10'h000, 1440);
      check("line exact", cnt[2], 16'h0);
      check("hblank exact", cnt[3], 16'h0);
      seg(EAV, 10'h3FE, 10'h000, 10'h002, 268);
      check("line near", cnt[2], 16'h1);
      seg(SAV, 10'h3FF, 10'h000, 10'h000, 1440);
      check("align twice", cnt[1], 16'h1);
      // Wrong V in both markers of one line
      seg(VEAV, 10'h3FF, 10'h000, 10'h000, 268);
      l0 = cnt[2];
      seg(VSAV, 10'h3FF, 10'h000, 10'h000, 1439);
      check("vblank", cnt[4], 16'h1);
      check("status word", cnt[5], 16'h1);
      check("field quiet", cnt[6], 16'h0);
      seg(EAV, 10'h3FF, 10'h000, 10'h000, 268);
      check("line short", cnt[2], 16'(l0 + 1));
      h0 = cnt[3];
      seg(SAV, 10'h3FF, 10'h000, 10'h003, 1440);
      check("hblank near", 16'(cnt[3] > h0), 16'h1);
      e = (cyc - clr_cyc) / SEC;
      check("elapsed", 16'(cnt[8] + 1 >= e && cnt[8] <= e + 1), 16'h1);
      check("errored", 16'(cnt[7] > 0), 16'h1);
      // Loss of signal used as the halting error
      @(negedge sys_clk_in) mask = 7'h01;
      src.idle();
      repeat (70) @(negedge sys_clk_in);
      check("los idle", los, 16'h1);
      check("los count", cnt[0], 16'h1);
      check("halted", halted, 16'h1);
      clr();
      check("restart", halted, 16'h0);
      stop_test();
   end
endmodule
`default_nettype wire
